// *** rtl/mdp_datapath.sv ***
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module mdp_datapath (
   input logic clk_sys_i,
   input logic rst_i,
   input logic [3:0] reg_addr_i,
   input logic [31:0] reg_wdata_i,
   input logic reg_wr_i,
   input logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input logic op_valid_i,
   input mdp_pkg::mdp_op_t op_code_i,
   input logic cond_pass_i,
   input logic flag_setting_product_i,
   input logic sel_n_top_i,
   input logic sel_m_top_i,
   input logic swap_i,
   input logic [31:0] opa_i,
   input logic [31:0] opb_i,
   input logic [31:0] addend_i,
   input logic [31:0] acc_lo_i,
   input logic [31:0] acc_hi_i,
   output logic res_valid_o,
   output logic [31:0] res_lo_o,
   output logic [31:0] res_hi_o,
   output logic wr_lo_o,
   output logic wr_hi_o,
   output logic [4:0] flags_o
);

   // ****************************************************************
   // Request decode
   // ****************************************************************
   logic ctrl_en_reg;
   logic [4:0] flags_reg;
   logic [4:0] flags_next;
   wire take = op_valid_i & ctrl_en_reg;
   wire exec = take & cond_pass_i;
   wire op_is_long = (op_code_i == mdp_pkg::unsigned_long_product_op) |
      (op_code_i == mdp_pkg::unsigned_long_double_add_op) |
      (op_code_i == mdp_pkg::unsigned_long_accumulate_op) |
      (op_code_i == mdp_pkg::signed_long_accumulate_op) |
      (op_code_i == mdp_pkg::signed_long_half_accumulate_op) |
      (op_code_i == mdp_pkg::signed_long_dual_accumulate_op);
   wire op_is_dual = (op_code_i == mdp_pkg::signed_dual_half_add_op) |
      (op_code_i == mdp_pkg::signed_long_dual_accumulate_op);
   wire op_is_word_half = op_code_i == mdp_pkg::signed_word_by_half_add_op;
   wire op_is_half_add = op_code_i == mdp_pkg::signed_half_product_add_op;

   // ****************************************************************
   // Multipliers
   // ****************************************************************
   // Low word of an unsigned product equals that of a signed one.
   wire [63:0] prod_u = opa_i * opb_i;
   wire [63:0] prod_s = $signed(opa_i) * $signed(opb_i);
   wire [15:0] n_half = sel_n_top_i ? opa_i[31:16] : opa_i[15:0];
   wire [15:0] m_half = sel_m_top_i ? opb_i[31:16] : opb_i[15:0];
   wire [15:0] m_lo_pair = swap_i ? opb_i[31:16] : opb_i[15:0];
   wire [15:0] m_hi_pair = swap_i ? opb_i[15:0] : opb_i[31:16];
   wire [15:0] mul0_a = op_is_dual ? opa_i[15:0] : n_half;
   wire [15:0] mul0_b = op_is_dual ? m_lo_pair : m_half;
   logic [31:0] p0;
   logic [31:0] p1;

   mdp_half_mul u_mul_lo (
      .a_i(mul0_a),
      .b_i(mul0_b),
      .p_o(p0)
   );

   mdp_half_mul u_mul_hi (
      .a_i(opa_i[31:16]),
      .b_i(m_hi_pair),
      .p_o(p1)
   );

   wire [47:0] prod_w = $signed(opa_i) * $signed(m_half);
   wire [31:0] w_top = prod_w[47:16];

   // ****************************************************************
   // Accumulators
   // ****************************************************************
   logic [31:0] acc32_sum;
   logic acc32_ovf;
   wire [31:0] acc32_x = op_is_word_half ? w_top : p0;

   mdp_sat_add u_acc32 (
      .x_i(acc32_x),
      .y_i(addend_i),
      .sum_o(acc32_sum),
      .ovf_o(acc32_ovf)
   );

   wire [63:0] acc64 = {acc_hi_i, acc_lo_i};
   wire [63:0] p0_x = {{32{p0[31]}}, p0};
   wire [63:0] p1_x = {{32{p1[31]}}, p1};
   wire [33:0] dual_sum = {{2{p0[31]}}, p0} + {{2{p1[31]}}, p1} +
      {{2{addend_i[31]}}, addend_i};
   wire [63:0] maal_sum = prod_u + {32'h0, acc_hi_i} +
      {32'h0, acc_lo_i};
   wire [63:0] unsigned_long_accumulate_op_sum = prod_u + acc64;
   wire [63:0] signed_long_accumulate_op_sum = prod_s + acc64;
   wire [63:0] lhalf_sum = p0_x + acc64;
   wire [63:0] ldual_sum = p0_x + p1_x + acc64;
   wire [31:0] mla_sum = prod_u[31:0] + addend_i;
   wire [31:0] mls_diff = addend_i - prod_u[31:0];

   // ****************************************************************
   // Result select
   // ****************************************************************
   logic [63:0] result;
   always_comb begin
      case (op_code_i)
         mdp_pkg::product_low_word_op: result = {32'h0, prod_u[31:0]};
         mdp_pkg::product_plus_addend_op: result = {32'h0, mla_sum};
         mdp_pkg::addend_minus_product_op: result = {32'h0, mls_diff};
         mdp_pkg::unsigned_long_product_op: result = prod_u;
         mdp_pkg::unsigned_long_double_add_op: result = maal_sum;
         mdp_pkg::unsigned_long_accumulate_op: result = unsigned_long_accumulate_op_sum;
         mdp_pkg::signed_half_product_add_op: begin
            result = {32'h0, acc32_sum};
         end
         mdp_pkg::signed_word_by_half_add_op: result = {32'h0, acc32_sum};
         mdp_pkg::signed_dual_half_add_op: result = {32'h0, dual_sum[31:0]};
         mdp_pkg::signed_long_accumulate_op: result = signed_long_accumulate_op_sum;
         mdp_pkg::signed_long_half_accumulate_op: result = lhalf_sum;
         mdp_pkg::signed_long_dual_accumulate_op: result = ldual_sum;
         default: result = 64'h0;
      endcase
   end

   // ****************************************************************
   // Flags
   // ****************************************************************
   wire nz_upd = exec & flag_setting_product_i &
      (op_code_i == mdp_pkg::product_low_word_op);
   wire q_set = exec & acc32_ovf &
      (op_is_half_add | op_is_word_half);
   wire stat_wr = reg_wr_i & (reg_addr_i == mdp_pkg::ADDR_STATUS);
   wire ctrl_wr = reg_wr_i & (reg_addr_i == mdp_pkg::ADDR_CTRL);
   wire q_clr = ctrl_wr & reg_wdata_i[mdp_pkg::CTRL_QCLR_BIT];

   // Hardware updates beat a software load in the same cycle, so no event
   // is lost. Only software may clear saturation, and a set still wins.
   always_comb begin
      flags_next = flags_reg;
      if (stat_wr) begin
         flags_next[mdp_pkg::FLAG_N] = reg_wdata_i[mdp_pkg::FLAG_N];
         flags_next[mdp_pkg::FLAG_Z] = reg_wdata_i[mdp_pkg::FLAG_Z];
         flags_next[mdp_pkg::FLAG_C] = reg_wdata_i[mdp_pkg::FLAG_C];
         flags_next[mdp_pkg::FLAG_V] = reg_wdata_i[mdp_pkg::FLAG_V];
      end
      if (nz_upd) begin
         flags_next[mdp_pkg::FLAG_N] = prod_u[31];
         flags_next[mdp_pkg::FLAG_Z] = (prod_u[31:0] == 32'h0);
      end
      if (q_clr) begin
         flags_next[mdp_pkg::FLAG_Q] = 1'b0;
      end
      if (q_set) begin
         flags_next[mdp_pkg::FLAG_Q] = 1'b1;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         flags_reg <= mdp_pkg::FLAGS_RST;
         ctrl_en_reg <= mdp_pkg::CTRL_EN_RST;
      end else begin
         flags_reg <= flags_next;
         if (ctrl_wr) begin
            ctrl_en_reg <= reg_wdata_i[mdp_pkg::CTRL_EN_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         res_valid_o <= 1'b0;
         wr_lo_o <= 1'b0;
         wr_hi_o <= 1'b0;
      end else begin
         res_valid_o <= take;
         wr_lo_o <= exec;
         wr_hi_o <= exec & op_is_long;
      end
   end

   // Result words only load on execution; a skipped operation keeps them.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         res_lo_o <= 32'h0;
         res_hi_o <= 32'h0;
      end else if (exec) begin
         res_lo_o <= result[31:0];
         res_hi_o <= result[63:32];
      end
   end

   wire [31:0] rd_mux = (reg_addr_i == mdp_pkg::ADDR_CTRL) ?
      {31'h0, ctrl_en_reg} :
      (reg_addr_i == mdp_pkg::ADDR_STATUS) ? {27'h0, flags_reg} : 32'h0;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

   assign flags_o = flags_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   wire go_mul = exec & (op_code_i == mdp_pkg::product_low_word_op);
   wire go_mla = exec & (op_code_i == mdp_pkg::product_plus_addend_op);
   wire go_mls = exec & (op_code_i == mdp_pkg::addend_minus_product_op);
   wire go_unsigned_long_product_op = exec & (op_code_i == mdp_pkg::unsigned_long_product_op);
   wire go_unsigned_long_accumulate_op = exec &
      (op_code_i == mdp_pkg::unsigned_long_accumulate_op);
   wire go_ulong = exec & (op_code_i == mdp_pkg::unsigned_long_product_op |
      op_code_i == mdp_pkg::unsigned_long_double_add_op |
      op_code_i == mdp_pkg::unsigned_long_accumulate_op);

   property p_mul_low;
      @(posedge clk_sys_i) disable iff (rst_i)
      go_mul |=> wr_lo_o && !wr_hi_o &&
         res_lo_o == 32'($past(opa_i) * $past(opb_i));
   endproperty
   a_mul_low: assert property (p_mul_low)
      else $error("plain multiply low word wrong");

   property p_mla;
      @(posedge clk_sys_i) disable iff (rst_i)
      go_mla |=> res_lo_o ==
         32'($past(opa_i) * $past(opb_i) + $past(addend_i));
   endproperty
   a_mla: assert property (p_mla)
      else $error("multiply-add result wrong");

   property p_mls;
      @(posedge clk_sys_i) disable iff (rst_i)
      go_mls |=> res_lo_o ==
         32'($past(addend_i) - $past(opa_i) * $past(opb_i));
   endproperty
   a_mls: assert property (p_mls)
      else $error("multiply-subtract result wrong");

   property p_nz;
      @(posedge clk_sys_i) disable iff (rst_i)
      nz_upd && !stat_wr |=> flags_o[mdp_pkg::FLAG_Z] == (res_lo_o == 32'h0)
         && flags_o[mdp_pkg::FLAG_N] == res_lo_o[31]
         && flags_o[2:1] == $past(flags_o[2:1]);
   endproperty
   a_nz: assert property (p_nz)
      else $error("flag-setting multiply flags wrong");

   property p_unsigned_long_product_op;
      @(posedge clk_sys_i) disable iff (rst_i)
      go_unsigned_long_product_op |=> wr_hi_o &&
         {res_hi_o, res_lo_o} == 64'($past(opa_i) * $past(opb_i));
   endproperty
   a_unsigned_long_product_op: assert property (p_unsigned_long_product_op)
      else $error("unsigned long product wrong");

   property p_unsigned_long_accumulate_op;
      @(posedge clk_sys_i) disable iff (rst_i)
      go_unsigned_long_accumulate_op |=> {res_hi_o, res_lo_o} == 64'(64'($past(opa_i) *
         $past(opb_i)) + {$past(acc_hi_i), $past(acc_lo_i)});
   endproperty
   a_unsigned_long_accumulate_op: assert property (p_unsigned_long_accumulate_op)
      else $error("unsigned long accumulate wrong");

   property p_ulong_flags;
      @(posedge clk_sys_i) disable iff (rst_i)
      go_ulong && !stat_wr && !q_clr |=> flags_o == $past(flags_o);
   endproperty
   a_ulong_flags: assert property (p_ulong_flags)
      else $error("unsigned long multiply changed flags");

   property p_cond_false;
      @(posedge clk_sys_i) disable iff (rst_i)
      take && !cond_pass_i && !reg_wr_i |=> !wr_lo_o && !wr_hi_o &&
         $stable(res_lo_o) && $stable(res_hi_o) && $stable(flags_o);
   endproperty
   a_cond_false: assert property (p_cond_false)
      else $error("failed condition changed state");

   property p_q_set;
      @(posedge clk_sys_i) disable iff (rst_i)
      q_set |=> flags_o[mdp_pkg::FLAG_Q] ##1
         (flags_o[mdp_pkg::FLAG_Q] || $past(q_clr));
   endproperty
   a_q_set: assert property (p_q_set)
      else $error("saturation flag not set on overflow");

   property p_q_sticky;
      @(posedge clk_sys_i) disable iff (rst_i)
      flags_o[mdp_pkg::FLAG_Q] && !q_clr |=> flags_o[mdp_pkg::FLAG_Q];
   endproperty
   a_q_sticky: assert property (p_q_sticky)
      else $error("saturation flag cleared by an operation");

endmodule // mdp_datapath

// *** rtl/mdp_pkg.sv ***
package mdp_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_QCLR_BIT = 1;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int FLAG_N = 4;
   localparam int FLAG_Z = 3;
   localparam int FLAG_C = 2;
   localparam int FLAG_V = 1;
   localparam int FLAG_Q = 0;
   localparam logic [4:0] FLAGS_RST = 5'h00;

   // ****************************************************************
   // Operation codes
   // ****************************************************************
   typedef enum logic [3:0] {
      product_low_word_op = 4'h0,
      product_plus_addend_op = 4'h1,
      addend_minus_product_op = 4'h3,
      unsigned_long_product_op = 4'h2,
      unsigned_long_double_add_op = 4'h6,
      unsigned_long_accumulate_op = 4'h7,
      signed_half_product_add_op = 4'h5,
      signed_word_by_half_add_op = 4'h4,
      signed_dual_half_add_op = 4'hc,
      signed_long_accumulate_op = 4'hd,
      signed_long_half_accumulate_op = 4'hf,
      signed_long_dual_accumulate_op = 4'he
   } mdp_op_t;

endpackage

// *** rtl/mdp_half_mul.sv ***
`timescale 1ns/1ps
module mdp_half_mul (
   input logic [15:0] a_i,
   input logic [15:0] b_i,
   output logic [31:0] p_o
);
   // A 16x16 signed product always fits 32 bits, so it never overflows.
   assign p_o = $signed(a_i) * $signed(b_i);
endmodule // mdp_half_mul

// *** rtl/mdp_sat_add.sv ***
`timescale 1ns/1ps
module mdp_sat_add (
   input logic [31:0] x_i,
   input logic [31:0] y_i,
   output logic [31:0] sum_o,
   output logic ovf_o
);
   logic [32:0] wide;
   assign wide = {x_i[31], x_i} + {y_i[31], y_i};
   assign sum_o = wide[31:0];
   assign ovf_o = wide[32] ^ wide[31];
endmodule // mdp_sat_add

// *** testbench/mdp_issuer_model.sv ***
`timescale 1ns/1ps
module mdp_issuer_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] lo_idx_i,
   input wire logic [3:0] hi_idx_i,
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic [31:0] res_lo_i,
   input wire logic [31:0] res_hi_i,
   output logic [31:0] acc_lo_o,
   output logic [31:0] acc_hi_o
);
   // ****************************************************************
   // Core register file
   // ****************************************************************
   // Only the thirteen general registers exist, so the stack pointer and
   // the program counter can never be handed out as operands.
   logic [31:0] gpr_reg [0:12];
   assign acc_lo_o = gpr_reg[lo_idx_i];
   assign acc_hi_o = gpr_reg[hi_idx_i];
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int i = 0; i < 13; i++) begin
            gpr_reg[i] <= 32'h1357_9bdf * (i + 1);
         end
      end else begin
         if (wr_lo_i) begin
            gpr_reg[lo_idx_i] <= res_lo_i;
         end
         if (wr_hi_i) begin
            gpr_reg[hi_idx_i] <= res_hi_i;
         end
      end
   end
endmodule // mdp_issuer_model

// *** testbench/mdp_datapath_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin \
   miscompares++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, (g), (x)); \
   end end
module mdp_datapath_tb_top;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0, lo_idx = 4'h0, hi_idx = 4'h1;
   logic [31:0] reg_wdata = 32'h0, opa = 32'h0, opb = 32'h0, addend = 32'h0;
   logic op_valid = 1'b0, cond_pass = 1'b0, fset = 1'b0;
   logic sn = 1'b0, sm = 1'b0, sw = 1'b0, res_valid, wr_lo, wr_hi;
   mdp_pkg::mdp_op_t op_code = mdp_pkg::product_low_word_op;
   logic [31:0] rdata, acc_lo, acc_hi, res_lo, res_hi;
   logic [4:0] flags, mflags = 5'h00;
   int miscompares = 0, n_checks = 0, k;
   logic cnd, fs;
   mdp_datapath u_mdp_datapath (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .op_valid_i(op_valid),
      .op_code_i(op_code), .cond_pass_i(cond_pass),
      .flag_setting_product_i(fset), .sel_n_top_i(sn), .sel_m_top_i(sm),
      .swap_i(sw), .opa_i(opa), .opb_i(opb), .addend_i(addend),
      .acc_lo_i(acc_lo), .acc_hi_i(acc_hi), .res_valid_o(res_valid),
      .res_lo_o(res_lo), .res_hi_o(res_hi), .wr_lo_o(wr_lo),
      .wr_hi_o(wr_hi), .flags_o(flags));
   mdp_issuer_model u_mdp_issuer_model (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .lo_idx_i(lo_idx), .hi_idx_i(hi_idx), .wr_lo_i(wr_lo),
      .wr_hi_i(wr_hi), .res_lo_i(res_lo), .res_hi_i(res_hi),
      .acc_lo_o(acc_lo), .acc_hi_o(acc_hi));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // ****************************************************************
   // Expected results
   // ****************************************************************
   function automatic logic [64:0] model(mdp_pkg::mdp_op_t op,
      logic [31:0] a, b, c, al, ah, logic xn, xm, xs);
      logic signed [63:0] ph, p0, p1, pw, ps;
      logic [15:0] hm;
      logic [31:0] x, s;
      logic [63:0] r;
      hm = xm ? b[31:16] : b[15:0];
      ph = $signed(xn ? a[31:16] : a[15:0]) * $signed(hm);
      p0 = $signed(a[15:0]) * $signed(xs ? b[31:16] : b[15:0]);
      p1 = $signed(a[31:16]) * $signed(xs ? b[15:0] : b[31:16]);
      pw = $signed(a) * $signed(hm);
      ps = $signed(a) * $signed(b);
      x = (op == mdp_pkg::signed_word_by_half_add_op) ? pw[47:16] : ph[31:0];
      s = x + c;
      case (op)
         mdp_pkg::product_plus_addend_op: r = a * b + c;
         mdp_pkg::addend_minus_product_op: r = c - a * b;
         mdp_pkg::unsigned_long_double_add_op: r = a * b + al + ah;
         mdp_pkg::unsigned_long_accumulate_op: r = a * b + {ah, al};
         mdp_pkg::signed_half_product_add_op: r = {32'h0, s};
         mdp_pkg::signed_word_by_half_add_op: r = {32'h0, s};
         mdp_pkg::signed_dual_half_add_op: r = p0 + p1 + c;
         mdp_pkg::signed_long_accumulate_op: r = ps + {ah, al};
         mdp_pkg::signed_long_half_accumulate_op: r = ph + {ah, al};
         mdp_pkg::signed_long_dual_accumulate_op: r = p0 + p1 + {ah, al};
         default: r = a * b;
      endcase
      return {(op inside {mdp_pkg::signed_half_product_add_op,
         mdp_pkg::signed_word_by_half_add_op}) && (x[31] == c[31]) &&
         (s[31] != x[31]), r};
   endfunction
   // ****************************************************************
   // Bus and operation tasks
   // ****************************************************************
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   task automatic run_op(input mdp_pkg::mdp_op_t op, input logic c_i, f_i,
      xn, xm, xs, input logic [31:0] a, b, c);
      logic [31:0] al, ah, prev, prevh;
      logic [64:0] e;
      logic lng;
      int j;
      @(posedge clk_sys_i);
      j = $urandom % 7;
      lo_idx <= 4'(j);
      hi_idx <= 4'(j + 1);
      #1;
      al = acc_lo;
      ah = acc_hi;
      prev = res_lo;
      prevh = res_hi;
      if (f_i) b = al;
      e = model(op, a, b, c, al, ah, xn, xm, xs);
      lng = op inside {mdp_pkg::unsigned_long_product_op,
         mdp_pkg::unsigned_long_double_add_op,
         mdp_pkg::unsigned_long_accumulate_op,
         mdp_pkg::signed_long_accumulate_op,
         mdp_pkg::signed_long_half_accumulate_op,
         mdp_pkg::signed_long_dual_accumulate_op};
      @(posedge clk_sys_i);
      op_valid <= 1'b1;
      op_code <= op;
      cond_pass <= c_i;
      fset <= f_i;
      sn <= xn;
      sm <= xm;
      sw <= xs;
      opa <= a;
      opb <= b;
      addend <= c;
      @(posedge clk_sys_i);
      op_valid <= 1'b0;
      #1;
      if (c_i && f_i) mflags[4:3] = {e[31], e[31:0] == 32'h0};
      if (c_i && e[64]) mflags[mdp_pkg::FLAG_Q] = 1'b1;
      `CHK(res_valid, 1'b1)
      `CHK(wr_lo, c_i)
      `CHK(wr_hi, c_i & lng)
      `CHK(res_lo, c_i ? e[31:0] : prev)
      if (c_i & lng) `CHK(res_hi, e[63:32])
      if (!c_i) `CHK(res_hi, prevh)
      `CHK(flags, mflags)
   endtask
   task automatic close_out;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      miscompares++;
      close_out;
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      void'($urandom(32'h9786));
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h1);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      for (k = 0; k < 16; k++) begin
         if (k[3:2] != 2'b10) run_op(mdp_pkg::mdp_op_t'(4'(k)), 1'b1, 1'b0,
            1'($urandom), 1'($urandom), 1'($urandom), $urandom, $urandom,
            $urandom);
      end
      repeat (60) begin
         k = $urandom % 16;
         if (k[3:2] == 2'b10) k = k - 8;
         cnd = ($urandom % 4) != 0;
         fs = 1'b0;
         if (k == 0) begin
            cnd = 1'b1;
            fs = 1'($urandom);
         end
         run_op(mdp_pkg::mdp_op_t'(4'(k)), cnd, fs, 1'($urandom),
            1'($urandom), 1'($urandom), $urandom, $urandom, $urandom);
      end
      run_op(mdp_pkg::product_low_word_op, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
         32'h0, 32'h0, 32'h0);
      wr(4'h4, 32'h0000_001e);
      mflags[4:1] = 4'hf;
      rd(4'h4, {27'h0, mflags});
      run_op(mdp_pkg::unsigned_long_double_add_op, 1'b1, 1'b0, 1'b0, 1'b0,
         1'b0, $urandom, $urandom, $urandom);
      run_op(mdp_pkg::signed_half_product_add_op, 1'b1, 1'b0, 1'b0, 1'b0,
         1'b0, 32'h8000, 32'h8000, 32'h4000_0000);
      run_op(mdp_pkg::signed_dual_half_add_op, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
         32'h7fff_8000, 32'h8000_7fff, 32'h7fff_ffff);
      wr(4'h0, 32'h3);
      mflags[mdp_pkg::FLAG_Q] = 1'b0;
      rd(4'h4, {27'h0, mflags});
      run_op(mdp_pkg::signed_word_by_half_add_op, 1'b1, 1'b0, 1'b0, 1'b1,
         1'b0, 32'h7fff_ffff, 32'h7fff_0000, 32'h7000_0000);
      rd(4'h4, {27'h0, mflags});
      wr(4'h0, 32'h0);
      @(posedge clk_sys_i);
      op_valid <= 1'b1;
      @(posedge clk_sys_i);
      op_valid <= 1'b0;
      #1;
      `CHK(res_valid, 1'b0)
      wr(4'h0, 32'h1);
      rd(4'h0, 32'h1);
      close_out;
   end
endmodule // mdp_datapath_tb_top
